// ### logic/tsr_pkg.sv
// Package for the touch status and result register bank
package tsr_pkg;

  // Register offsets
  localparam logic [7:0] OFS_DEVICE_CONDITION = 8'h00;
  localparam logic [7:0] OFS_PRESS_OUTPUT_STATE = 8'h01;
  localparam logic [7:0] OFS_CHAN0_RESULT_LOW = 8'h02;
  localparam logic [7:0] OFS_CHAN0_RESULT_HIGH = 8'h03;
  localparam logic [7:0] OFS_CHAN1_RESULT_LOW = 8'h04;
  localparam logic [7:0] OFS_CHAN1_RESULT_HIGH = 8'h05;
  localparam logic [7:0] OFS_CHAN2_RESULT_LOW = 8'h06;
  localparam logic [7:0] OFS_CHAN2_RESULT_HIGH = 8'h07;
  localparam logic [7:0] OFS_CHAN3_RESULT_LOW = 8'h08;
  localparam logic [7:0] OFS_CHAN3_RESULT_HIGH = 8'h09;

  // Device condition bit positions
  localparam int BIT_ANY_PRESS = 7;
  localparam int BIT_INIT_DONE = 6;
  localparam int BIT_WRITE_PERMIT = 5;
  localparam int BIT_SATURATION = 4;
  localparam int BIT_SEQ_WDOG = 3;
  localparam int BIT_OSC_START = 2;
  localparam int BIT_PRESS_TIMEOUT = 1;
  localparam int BIT_REG_INTEGRITY = 0;

  // Press output state bit positions
  localparam int BIT_FRESH_SAMPLE = 4;
  localparam int BIT_PRESS_LSB = 0;

  // Reset values and the value read at unmapped offsets
  localparam logic [7:0] RST_DEVICE_CONDITION = 8'h40;
  localparam logic [7:0] RST_PRESS_OUTPUT_STATE = 8'h00;
  localparam logic [7:0] RST_RESULT_BYTE = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Result geometry and extreme codes
  localparam int NUM_CHAN = 4;
  localparam int RESULT_W = 12;
  localparam logic [11:0] RESULT_MAX = 12'h7ff;
  localparam logic [11:0] RESULT_MIN = 12'h800;

  // Press timeout: time in seconds, cycles from the 100 MHz clock
  localparam longint PRESS_LIMIT_S = 50;
  localparam longint CLK_HZ = 100_000_000;
  localparam longint PRESS_LIMIT_CYCLES = PRESS_LIMIT_S * CLK_HZ;
  localparam int PRESS_CNT_W = 33;

  // Error events from the sensing core, one-cycle pulses
  typedef struct packed {
    logic seq_fault;
    logic osc_fail;
    logic reg_integrity_err;
  } tsr_events_t;

  // All four channel results
  typedef logic [NUM_CHAN-1:0][RESULT_W-1:0] tsr_results_t;

endpackage : tsr_pkg

// ### logic/tsr_regs.sv
// Status and result register bank of the four-channel touch sensor
`timescale 1ns/100ps
module tsr_regs #(
  parameter logic [32:0] PRESS_LIMIT_CYCLES =
    33'(tsr_pkg::PRESS_LIMIT_CYCLES)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register read port from the serial interface engine
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  // Status inputs from the sensing core
  input wire logic init_done,
  input wire logic write_permit,
  input wire logic press_limit_disable,
  input wire tsr_pkg::tsr_events_t events,
  // Press states and conversion results
  input wire logic [3:0] press_state,
  input wire logic capture_busy,
  input wire logic sample_valid,
  input wire tsr_pkg::tsr_results_t results,
  // Conversion halt request to the sequencer
  output logic conv_halt
);

  logic [7:0] cond_reg;
  logic [3:0] press_reg;
  logic fresh_reg;
  tsr_pkg::tsr_results_t result_reg;
  logic [3:0][3:0] high_shadow_reg;
  logic [3:0] high_pend_reg;
  logic [3:0] timed_out;
  logic sat_hit;
  logic rd_cond;
  logic rd_out;
  logic [3:0] rd_low;
  logic [3:0] rd_high;
  logic [7:0] rd_next;

  // Offset of a channel's low result byte
  function automatic logic [7:0] low_ofs(input int ch);
    unique case (ch)
      0: low_ofs = tsr_pkg::OFS_CHAN0_RESULT_LOW;
      1: low_ofs = tsr_pkg::OFS_CHAN1_RESULT_LOW;
      2: low_ofs = tsr_pkg::OFS_CHAN2_RESULT_LOW;
      default: low_ofs = tsr_pkg::OFS_CHAN3_RESULT_LOW;
    endcase
  endfunction : low_ofs

  // Offset of a channel's high result byte
  function automatic logic [7:0] high_ofs(input int ch);
    unique case (ch)
      0: high_ofs = tsr_pkg::OFS_CHAN0_RESULT_HIGH;
      1: high_ofs = tsr_pkg::OFS_CHAN1_RESULT_HIGH;
      2: high_ofs = tsr_pkg::OFS_CHAN2_RESULT_HIGH;
      default: high_ofs = tsr_pkg::OFS_CHAN3_RESULT_HIGH;
    endcase
  endfunction : high_ofs

  // Read strobes per register
  assign rd_cond = rd_en && (rd_addr == tsr_pkg::OFS_DEVICE_CONDITION);
  assign rd_out = rd_en && (rd_addr == tsr_pkg::OFS_PRESS_OUTPUT_STATE);

  // Per-channel decode, result pairing and press timers
  for (genvar ch = 0; ch < tsr_pkg::NUM_CHAN; ch++) begin : g_chan
    logic [tsr_pkg::PRESS_CNT_W-1:0] press_cnt_reg;

    assign rd_low[ch] = rd_en && (rd_addr == low_ofs(ch));
    assign rd_high[ch] = rd_en && (rd_addr == high_ofs(ch));

    // Low read freezes the matching high nibble until the high read
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        high_shadow_reg[ch] <= 4'h0;
        high_pend_reg[ch] <= 1'b0;
      end else if (rd_low[ch]) begin
        high_shadow_reg[ch] <= result_reg[ch][11:8];
        high_pend_reg[ch] <= 1'b1;
      end else if (rd_high[ch]) begin
        high_pend_reg[ch] <= 1'b0;
      end
    end

    // Press duration counter, saturates one past the limit
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        press_cnt_reg <= '0;
      end else if (!press_state[ch]) begin
        press_cnt_reg <= '0;
      end else if (press_cnt_reg <= PRESS_LIMIT_CYCLES) begin
        press_cnt_reg <= press_cnt_reg + 33'h000000001;
      end
    end

    // Longer than the limit: count has passed it
    assign timed_out[ch] = press_cnt_reg > PRESS_LIMIT_CYCLES;
  end

  // Saturation detect on the incoming sample
  always_comb begin
    sat_hit = 1'b0;
    for (int ch = 0; ch < tsr_pkg::NUM_CHAN; ch++) begin
      if (results[ch] == tsr_pkg::RESULT_MAX ||
          results[ch] == tsr_pkg::RESULT_MIN) begin
        sat_hit = 1'b1;
      end
    end
  end

  // Result capture, all channels from one conversion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_reg <= '0;
    end else if (sample_valid) begin
      result_reg <= results;
    end
  end

  // Live press states
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      press_reg <= 4'h0;
    end else begin
      press_reg <= press_state;
    end
  end

  // Fresh-sample flag: set wins over clear by read or capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fresh_reg <= 1'b0;
    end else if (sample_valid) begin
      fresh_reg <= 1'b1;
    end else if (capture_busy || rd_out) begin
      fresh_reg <= 1'b0;
    end
  end

  // Condition bits: init done and write permit follow their inputs, the rest are sticky and cleared by a condition read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cond_reg <= tsr_pkg::RST_DEVICE_CONDITION;
    end else begin
      cond_reg[tsr_pkg::BIT_INIT_DONE] <= init_done;
      cond_reg[tsr_pkg::BIT_WRITE_PERMIT] <= write_permit;
      cond_reg[tsr_pkg::BIT_ANY_PRESS] <= (|press_state) ||
        (cond_reg[tsr_pkg::BIT_ANY_PRESS] && !rd_cond);
      cond_reg[tsr_pkg::BIT_SATURATION] <= (sample_valid && sat_hit) ||
        (cond_reg[tsr_pkg::BIT_SATURATION] && !rd_cond);
      cond_reg[tsr_pkg::BIT_SEQ_WDOG] <= events.seq_fault ||
        (cond_reg[tsr_pkg::BIT_SEQ_WDOG] && !rd_cond);
      cond_reg[tsr_pkg::BIT_OSC_START] <= events.osc_fail ||
        (cond_reg[tsr_pkg::BIT_OSC_START] && !rd_cond);
      cond_reg[tsr_pkg::BIT_PRESS_TIMEOUT] <=
        ((|timed_out) && !press_limit_disable) ||
        (cond_reg[tsr_pkg::BIT_PRESS_TIMEOUT] && !rd_cond);
      cond_reg[tsr_pkg::BIT_REG_INTEGRITY] <= events.reg_integrity_err ||
        (cond_reg[tsr_pkg::BIT_REG_INTEGRITY] && !rd_cond);
    end
  end

  // Sequencer fault halts conversions until reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_halt <= 1'b0;
    end else if (events.seq_fault) begin
      conv_halt <= 1'b1;
    end
  end

  // Read multiplexer
  always_comb begin
    rd_next = tsr_pkg::RD_UNMAPPED;
    if (rd_cond) begin
      rd_next = cond_reg;
    end else if (rd_out) begin
      rd_next = 8'h00;
      rd_next[tsr_pkg::BIT_FRESH_SAMPLE] = fresh_reg;
      rd_next[tsr_pkg::BIT_PRESS_LSB +: 4] = press_reg;
    end else begin
      for (int ch = 0; ch < tsr_pkg::NUM_CHAN; ch++) begin
        if (rd_low[ch]) begin
          rd_next = result_reg[ch][7:0];
        end
        if (rd_high[ch]) begin
          rd_next = {4'h0, high_pend_reg[ch] ? high_shadow_reg[ch]
                                             : result_reg[ch][11:8]};
        end
      end
    end
  end

  // Read data captured in the same edge the clears take effect
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= tsr_pkg::RST_RESULT_BYTE;
    end else if (rd_en) begin
      rd_data <= rd_next;
    end
  end

endmodule : tsr_regs

// ### test/tsr_host.sv
// Host model that reads the register bank on behalf of the serial engine
`timescale 1ns/100ps
module tsr_host (
  // Clock
  input wire logic clk,
  // Read port
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  initial begin
    rd_en = 1'b0;
    rd_addr = 8'h5a;
  end
  // One read; address scrambled when idle, never writes
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk);
    d = rd_data;
    rd_en = 1'b0;
    rd_addr = ~a;
  endtask : rd
endmodule : tsr_host

// ### test/tsr_regs_bench.sv
// Self-checking bench for the touch status and result register bank
`timescale 1ns/100ps
module tsr_regs_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic init_done = 1'b1;
  logic write_permit = 1'b0;
  logic press_limit_disable = 1'b1;
  tsr_pkg::tsr_events_t events = 3'h0;
  logic [3:0] press_state = 4'h0;
  logic capture_busy = 1'b0;
  logic sample_valid = 1'b0;
  tsr_pkg::tsr_results_t results = '0;
  logic conv_halt;
  logic [7:0] d;
  int miscompares = 0;
  int comparisons = 0;
  // Offset in upper byte, expected read in lower byte
  logic [15:0] rows [13] = '{16'h0223, 16'h0301, 16'h04ff, 16'h0507,
    16'h0600, 16'h0708, 16'h08bc, 16'h090a, 16'h0a00, 16'h0110,
    16'h0100, 16'h0070, 16'h0060};
  always #5 clk = ~clk;
  tsr_regs #(.PRESS_LIMIT_CYCLES(33'd20)) i_dut (.clk, .rst_n, .rd_en,
    .rd_addr, .rd_data, .init_done, .write_permit, .press_limit_disable,
    .events, .press_state, .capture_busy, .sample_valid, .results,
    .conv_halt);
  tsr_host i_host (.clk, .rd_en, .rd_addr, .rd_data);
  // Compare and count
  task automatic chk(input logic [7:0] s, input logic [7:0] e,
    input string n);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk(d, e, $sformatf("offset %h", a));
  endtask : rc
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic print_verdict();
    $display("Comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // Watchdog
  initial begin
    #100us;
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    rc(8'h00, 8'h40);
    rc(8'h01, 8'h00);
    rc(8'h03, 8'h00);
    chk({7'h0, conv_halt}, 8'h00, "halt");
    write_permit = 1'b1;
    results = {12'habc, 12'h800, 12'h7ff, 12'h123};
    pulse(sample_valid);
    foreach (rows[i]) rc(rows[i][15:8], rows[i][7:0]);
    @(negedge clk);
    events = 3'h7;
    @(negedge clk);
    events = 3'h0;
    rc(8'h00, 8'h6d);
    chk({7'h0, conv_halt}, 8'h01, "halt");
    rc(8'h00, 8'h60);
    fork
      rc(8'h00, 8'h60);
      begin
        @(negedge clk);
        events = 3'h2;
        @(negedge clk);
        events = 3'h0;
      end
    join
    rc(8'h00, 8'h64);
    press_state = 4'h5;
    repeat (30) @(negedge clk);
    rc(8'h01, 8'h05);
    rc(8'h00, 8'he0);
    press_limit_disable = 1'b0;
    repeat (5) @(negedge clk);
    rc(8'h00, 8'he2);
    press_state = 4'h0;
    rc(8'h00, 8'he2);
    rc(8'h00, 8'h60);
    rc(8'h08, 8'hbc);
    results[3] = 12'h5a5;
    pulse(sample_valid);
    rc(8'h09, 8'h0a);
    rc(8'h08, 8'ha5);
    rc(8'h09, 8'h05);
    pulse(capture_busy);
    rc(8'h01, 8'h00);
    init_done = 1'b0;
    rc(8'h00, 8'h30);
    init_done = 1'b1;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk({7'h0, conv_halt}, 8'h00, "halt");
    rc(8'h00, 8'h60);
    rc(8'h09, 8'h00);
    print_verdict();
  end
endmodule : tsr_regs_bench

// ### test/tsr_regs_chk.sv
// Assertion checker for the touch status and result register bank
`timescale 1ns/100ps
module tsr_regs_chk #(
  parameter logic [32:0] PRESS_LIMIT_CYCLES = 33'd20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Read port
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  // Status inputs and halt output
  input wire tsr_pkg::tsr_events_t events,
  input wire logic [3:0] press_state,
  input wire logic conv_halt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Sticky flags seen by the next condition read, and halt held after a sequencer fault
  a_any_press: assert property (
    |press_state ##1 rd_en && rd_addr == 8'h00 |=> rd_data[7])
    else $error("any press bit missing");
  a_seq_flag: assert property (
    events.seq_fault ##1 rd_en && rd_addr == 8'h00 |=> rd_data[3])
    else $error("sequencer fault bit missing");
  a_osc_flag: assert property (
    events.osc_fail ##1 rd_en && rd_addr == 8'h00 |=> rd_data[2])
    else $error("oscillator bit missing");
  a_integ_flag: assert property (
    events.reg_integrity_err ##1 rd_en && rd_addr == 8'h00
    |=> rd_data[0])
    else $error("integrity bit missing");
  a_halt_sticky: assert property (
    events.seq_fault |=> conv_halt [*3])
    else $error("halt not held after fault");
  // Clear on read leaves event bits low when no event recurs
  a_clear_read: assert property (
    rd_en && rd_addr == 8'h00 && events == 3'h0 ##1 events == 3'h0
    ##1 rd_en && rd_addr == 8'h00 && events == 3'h0
    |=> rd_data[3:2] == 2'h0 && !rd_data[0])
    else $error("event bits not cleared by read");
  // Field layout of state and result bytes
  a_out_state: assert property (
    rd_en && rd_addr == 8'h01 |=> rd_data[7:5] == 3'h0
    && rd_data[3:0] == $past(press_state, 2))
    else $error("output state layout wrong");
  a_high_rsvd: assert property (
    rd_en && rd_addr inside {8'h03, 8'h05, 8'h07, 8'h09}
    |=> rd_data[7:4] == 4'h0)
    else $error("high byte reserved bits set");
  // Main scenarios
  c_press_read: cover property (rd_en && rd_addr == 8'h00 ##1 rd_data[7]);
  c_halt: cover property (conv_halt);
  c_chan3_high: cover property (rd_en && rd_addr == 8'h09);
endmodule : tsr_regs_chk
bind tsr_regs tsr_regs_chk #(.PRESS_LIMIT_CYCLES(PRESS_LIMIT_CYCLES)) i_chk (
  .clk, .rst_n, .rd_en, .rd_addr, .rd_data, .events, .press_state,
  .conv_halt);
